/* rtl/ghs_pkg.sv */
// package of constants and types for the rate-sensor health and spi port
package ghs_pkg;

  // ==========================================================
  // message framing
  localparam int unsigned MSG_BYTES = 6;
  localparam int unsigned MSG_BITS = 48;
  localparam int unsigned BIT_CNT_W = 6;
  localparam logic [5:0] LAST_BIT = 6'h2f;

  // ==========================================================
  // command byte fields
  localparam int unsigned CMD_FACTORY_BIT = 7;
  localparam int unsigned CMD_SELF_TEST_BIT = 6;
  localparam int unsigned CMD_RANGE_SRC_BIT = 5;

  // ==========================================================
  // status byte fields and fixed codes
  localparam int unsigned STS_FAIL_BIT = 7;
  localparam int unsigned STS_BAD_CSUM_BIT = 4;
  localparam int unsigned STS_SELF_TEST_BIT = 3;
  localparam logic [1:0] STS_MSG_TYPE = 2'h0;
  localparam logic [2:0] STS_NORMAL = 3'h1;

  // ==========================================================
  // rate and temperature
  // 150 deg/s offset at the reset-default scale of 32 codes per deg/s
  localparam int unsigned SELF_TEST_DPS = 150;
  localparam int unsigned RATE_CODES_PER_DPS = 32;
  localparam logic [15:0] SELF_TEST_OFFSET =
    16'(SELF_TEST_DPS * RATE_CODES_PER_DPS);
  // temperature scale 2.75 codes per degree, 0 deg reads 512
  localparam logic [15:0] TEMP_ZERO_CODE = 16'h0200;
  localparam logic [15:0] TEMP_25C_CODE = 16'h0258;
  localparam logic [15:0] TEMP_TOL_CODES = 16'h0014;

  // ==========================================================
  // settling: loops must read good for this long after startup
  localparam int unsigned SETTLE_US = 50;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  localparam logic [12:0] SETTLE_W_MAX = 13'h1fff;
  // cycles for the check synchronisers to fill before the power-up capture
  localparam int unsigned SYNC_FILL = 2;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic calib_parity_ok;
    logic trim_conv_ok;
    logic drive_too_high;
    logic level_too_low;
    logic demod_saturated;
    logic quad_excess;
  } ghs_checks_t;

  typedef struct packed {
    logic [15:0] rate;
    logic [15:0] temp;
  } ghs_sample_t;

  typedef struct packed {
    logic self_test;
    logic range_spi;
    logic [1:0] range_sel;
  } ghs_settings_t;

  localparam ghs_settings_t SETTINGS_RESET = '{1'b0, 1'b0, 2'h0};

  typedef enum logic [2:0] {
    HS_START = 3'b001,
    HS_SETTLE = 3'b010,
    HS_RUN = 3'b100
  } ghs_hstate_t;

  function automatic logic [7:0] ghs_csum(input logic [39:0] b);
    logic [7:0] s;
    s = b[39:32] + b[31:24] + b[23:16] + b[15:8] + b[7:0];
    return ~s;
  endfunction

endpackage

/* rtl/ghs_spi_link.sv */
// spi mode 0 slave shift logic running on the host serial clock
`timescale 1ns/1ps
`default_nettype none

module ghs_spi_link (
  // link clock and select
  input wire logic sclk_i,
  input wire logic ss_n_i,
  // serial data
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // reply loaded at frame start, command out at frame end
  input wire logic [47:0] reply_i,
  output logic [47:0] cmd_o,
  output logic done_tgl_o
);

  logic [5:0] cnt_q;
  logic [47:0] rx_q;
  logic [47:0] tx_q;
  logic first_q;
  logic done_q;

  // ==========================================================
  // receive: sample on rising edge; select high resets count
  // so a short frame is dropped without a done event; done stands
  // for one link clock after the last bit, or until select rises,
  // so the system side needs a few of its clocks in that time
  always_ff @(posedge sclk_i or posedge ss_n_i) begin
    if (ss_n_i) begin
      cnt_q <= 6'h0;
      rx_q <= 48'h0;
      done_q <= 1'b0;
    end else begin
      rx_q <= {rx_q[46:0], mosi_i};
      done_q <= (cnt_q == ghs_pkg::LAST_BIT);
      if (cnt_q == ghs_pkg::LAST_BIT) begin
        cnt_q <= 6'h0;
      end else begin
        cnt_q <= cnt_q + 6'h1;
      end
    end
  end

  // full command latched on the last edge; held stable for the crossing
  always_ff @(posedge sclk_i) begin
    if (!ss_n_i && cnt_q == ghs_pkg::LAST_BIT) begin
      cmd_o <= {rx_q[46:0], mosi_i};
    end
  end

  // ==========================================================
  // transmit: msb out before first rise, shift on falling edges
  always_ff @(negedge sclk_i or posedge ss_n_i) begin
    if (ss_n_i) begin
      first_q <= 1'b1;
      tx_q <= 48'h0;
    end else begin
      first_q <= 1'b0;
      tx_q <= first_q ? {reply_i[46:0], 1'b0} : {tx_q[46:0], 1'b0};
    end
  end

  assign miso_o = first_q ? reply_i[47] : tx_q[47];
  assign miso_oe_o = ~ss_n_i;
  assign done_tgl_o = done_q;

endmodule

`default_nettype wire

/* rtl/ghs_top.sv */
// rate-sensor health monitor, self-test and spi message port
// Contract
// - all health checks gate into one output, low on any failure
// - calibration memory parity fault at power-up forces health low
// - bad trim conversion check at power-up forces health low
// - amplitude loop drive above upper limit forces health low
// - amplitude loop level below lower limit forces health low
// - health stays low after startup until loops settle
// - rate demodulator saturation forces health low
// - excessive quadrature magnitude forces health low
// - message checksum failure reported as its own status flag
// - active self-test adds 150 deg/s equivalent offset to rate
// - self-test requested by pin in analogue mode, command in digital
// - enabled self-test holds health output low
// - temperature readable only over the serial port
// - temperature at 2.75 codes per degree, 25 C near 600
// - interface-select high enables converter and serial pin roles; the serial port here runs in both modes
// - serial port is a mode 0 slave
// - each frame swaps six bytes each way at once
// - last byte is inverted low byte of sum of first five
// - bad checksum command ignored, bit 4 set in next reply
// - command bit 6 enables or disables self-test
// - status bit 7 set on failure or while self-test enabled
`timescale 1ns/1ps
`default_nettype none

module ghs_top (
  // system clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // mode pins
  input wire logic iface_sel_i,
  input wire logic self_test_pin_i,
  // health inputs from analogue core
  input wire ghs_pkg::ghs_checks_t checks_i,
  input wire ghs_pkg::ghs_sample_t sample_i,
  // serial link
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // core controls
  output logic health_ok_o,
  output logic self_test_o,
  output logic adc_en_o,
  output logic [15:0] rate_o,
  output logic [1:0] range_sel_o,
  output logic range_spi_o
);

  // ==========================================================
  // reset release
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================
  // pin synchronisers
  logic [1:0] sel_sync_q;
  logic [1:0] stp_sync_q;
  logic [5:0] chk_s1_q;
  logic [5:0] chk_s2_q;
  ghs_pkg::ghs_checks_t chk;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sel_sync_q <= 2'h0;
      stp_sync_q <= 2'h0;
    end else begin
      sel_sync_q <= {sel_sync_q[0], iface_sel_i};
      stp_sync_q <= {stp_sync_q[0], self_test_pin_i};
    end
  end

  // one two-stage synchroniser per health check line
  for (genvar g = 0; g < 6; g++) begin : g_chk_sync
    always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
        chk_s1_q[g] <= 1'b0;
        chk_s2_q[g] <= 1'b0;
      end else begin
        chk_s1_q[g] <= checks_i[g];
        chk_s2_q[g] <= chk_s1_q[g];
      end
    end
  end
  assign chk = ghs_pkg::ghs_checks_t'(chk_s2_q);

  // select synchroniser resets to the idle (deselected) level so the
  // reply is reloaded right after reset rather than held at zero
  logic [1:0] ss_sync_q;
  logic ss_idle;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ss_sync_q <= 2'h3;
    end else begin
      ss_sync_q <= {ss_sync_q[0], ss_n_i};
    end
  end
  assign ss_idle = ss_sync_q[1];

  // ==========================================================
  // serial link in its own clock domain
  // miso and its enable follow select at once, so they are not retimed
  logic [47:0] reply_q;
  logic [47:0] link_cmd;
  logic link_tgl;

  ghs_spi_link u_link (
    .sclk_i(sclk_i),
    .ss_n_i(ss_n_i),
    .mosi_i(mosi_i),
    .miso_o(miso_o),
    .miso_oe_o(miso_oe_o),
    .reply_i(reply_q),
    .cmd_o(link_cmd),
    .done_tgl_o(link_tgl)
  );

  // done level crosses in two stages; its rising edge marks a full frame,
  // and the command word has stood still since the link raised it
  logic [2:0] tgl_sync_q;
  logic frame_done;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tgl_sync_q <= 3'h0;
    end else begin
      tgl_sync_q <= {tgl_sync_q[1:0], link_tgl};
    end
  end
  assign frame_done = tgl_sync_q[1] & ~tgl_sync_q[2];

  // ==========================================================
  // command decode
  logic csum_ok;
  logic [7:0] cmd_byte;

  assign cmd_byte = link_cmd[47:40];
  assign csum_ok = (link_cmd[7:0] == ghs_pkg::ghs_csum(link_cmd[47:8]));

  ghs_pkg::ghs_settings_t set_q;
  logic bad_csum_q;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      bad_csum_q <= 1'b0;
    end else if (frame_done) begin
      bad_csum_q <= ~csum_ok;
    end
  end

  // a refused frame leaves the settings of the last good one in force
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      set_q <= ghs_pkg::SETTINGS_RESET;
    end else if (frame_done && csum_ok) begin
      set_q.self_test <= cmd_byte[ghs_pkg::CMD_SELF_TEST_BIT];
      set_q.range_spi <= cmd_byte[ghs_pkg::CMD_RANGE_SRC_BIT];
      set_q.range_sel <= cmd_byte[4:3];
    end
  end

  // ==========================================================
  // self-test source follows mode
  logic digital;
  logic self_test;

  assign digital = sel_sync_q[1];
  assign self_test = digital ? set_q.self_test : stp_sync_q[1];

  // ==========================================================
  // health state: startup tests then settling before pass
  ghs_pkg::ghs_hstate_t hs_q;
  logic [12:0] settle_q;
  logic boot_fail_q;
  logic loops_ok;
  logic run_ok;

  assign loops_ok = ~chk.drive_too_high & ~chk.level_too_low;
  assign run_ok = loops_ok & ~chk.demod_saturated
    & ~chk.quad_excess;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      hs_q <= ghs_pkg::HS_START;
      settle_q <= 13'h0;
    end else begin
      unique case (hs_q)
        ghs_pkg::HS_START: begin
          // wait for the check synchronisers to fill first
          if (settle_q == 13'(ghs_pkg::SYNC_FILL)) begin
            settle_q <= 13'h0;
            hs_q <= ghs_pkg::HS_SETTLE;
          end else begin
            settle_q <= settle_q + 13'h1;
          end
        end
        ghs_pkg::HS_SETTLE: begin
          if (!loops_ok) begin
            settle_q <= 13'h0;
          end else if (settle_q ==
              13'(ghs_pkg::SETTLE_CYCLES - 1)) begin
            hs_q <= ghs_pkg::HS_RUN;
          end else begin
            settle_q <= settle_q + 13'h1;
          end
        end
        ghs_pkg::HS_RUN: begin
          hs_q <= ghs_pkg::HS_RUN;
        end
        default: begin
          hs_q <= ghs_pkg::HS_START;
        end
      endcase
    end
  end

  // power-up results captured once, on the last cycle of the start state
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      boot_fail_q <= 1'b0;
    end else if (hs_q == ghs_pkg::HS_START &&
        settle_q == 13'(ghs_pkg::SYNC_FILL)) begin
      boot_fail_q <= ~chk.calib_parity_ok
        | ~chk.trim_conv_ok;
    end
  end

  logic health_d;
  assign health_d = (hs_q == ghs_pkg::HS_RUN) & ~boot_fail_q & run_ok
    & ~self_test;

  // ==========================================================
  // outputs and rate with self-test offset
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      health_ok_o <= 1'b0;
      self_test_o <= 1'b0;
      adc_en_o <= 1'b0;
    end else begin
      health_ok_o <= health_d;
      self_test_o <= self_test;
      adc_en_o <= digital;
    end
  end

  // rate passes through, offset only while the self-test runs
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rate_o <= 16'h0;
    end else begin
      rate_o <= self_test ? sample_i.rate + ghs_pkg::SELF_TEST_OFFSET
                          : sample_i.rate;
    end
  end

  // range fields follow the last good command
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      range_sel_o <= 2'h0;
      range_spi_o <= 1'b0;
    end else begin
      range_sel_o <= set_q.range_sel;
      range_spi_o <= set_q.range_spi;
    end
  end

  // ==========================================================
  // reply: status, rate, temperature, checksum; reloaded between
  // frames so the link sees a stable word at frame start
  logic [7:0] status_b;
  logic [39:0] body;

  // status byte: fail, message type, bad checksum, self-test, normal code
  function automatic logic [7:0] status_of(input logic fail,
      input logic bad, input logic st);
    return {fail, ghs_pkg::STS_MSG_TYPE, bad, st, ghs_pkg::STS_NORMAL};
  endfunction

  assign status_b = status_of(~health_d | self_test,
                              bad_csum_q, self_test);
  assign body = {status_b, rate_o, sample_i.temp};

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      reply_q <= 48'h0;
    end else if (ss_idle) begin
      reply_q <= {body, ghs_pkg::ghs_csum(body)};
    end
  end

endmodule

`default_nettype wire

/* tb/ghs_host.sv */
// host master model driving mode 0 frames on its own serial clock
`timescale 1ns/1ps
`default_nettype none

module ghs_host (
  // serial link
  output logic sclk_o,
  output logic ss_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  // ============================================================
  // frame engine
  // clock stands low between frames; mosi has no pull, so it idles at
  // the inverse of its last bit rather than a friendly value
  initial begin
    sclk_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // msb first; a count short of 48 aborts the frame on purpose
  task automatic xfer(input logic [47:0] tx, input int nbits,
                      output logic [47:0] rx);
    rx = '0;
    #3.3 ss_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi_o = tx[47 - i];
      #80 sclk_o = 1'b1;
      rx = {rx[46:0], miso_i};
      #80 sclk_o = 1'b0;
      if (i % 8 == 7) #200;
    end
    #80 ss_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #1500;
  endtask
endmodule

`default_nettype wire

/* tb/ghs_top_sva.sv */
// assertions on the ports of the health monitor and spi message port
`timescale 1ns/1ps
`default_nettype none

module ghs_top_sva (
  // watched ports
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic iface_sel_i,
  input wire logic self_test_pin_i,
  input wire ghs_pkg::ghs_checks_t checks_i,
  input wire ghs_pkg::ghs_sample_t sample_i,
  input wire logic ss_n_i,
  input wire logic miso_oe_o,
  input wire logic health_ok_o,
  input wire logic self_test_o,
  input wire logic adc_en_o,
  input wire logic [15:0] rate_o
);
  // ============================================================
  // cycles since reset release, saturating
  logic [12:0] up_q;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) up_q <= '0;
    else if (up_q != 13'h1fff) up_q <= up_q + 13'h1;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  settle_hold_a: assert property (
    health_ok_o |-> up_q >= 13'h1388) else $error("health before settle");
  loop_fault_a: assert property (
    (checks_i.drive_too_high || checks_i.level_too_low)[*5] |->
    !health_ok_o) else $error("loop fault not flagged");
  signal_fault_a: assert property (
    (checks_i.demod_saturated || checks_i.quad_excess)[*5] |->
    !health_ok_o) else $error("signal fault not flagged");
  test_health_a: assert property (
    self_test_o[*2] |-> !health_ok_o) else $error("health high in test");
  test_offset_a: assert property (
    (self_test_o && $stable(sample_i.rate))[*4] |->
    rate_o == 16'(sample_i.rate + ghs_pkg::SELF_TEST_OFFSET))
    else $error("self-test offset wrong");
  rate_pass_a: assert property (
    (!self_test_o && $stable(sample_i.rate))[*4] |->
    rate_o == sample_i.rate) else $error("rate altered");
  drive_enable_a: assert property (
    $stable(ss_n_i) |-> miso_oe_o == !ss_n_i) else $error("oe wrong");
  conv_enable_a: assert property (
    (up_q >= 13'h2 ##0 $stable(iface_sel_i)[*4]) |->
    adc_en_o == iface_sel_i)
    else $error("converter enable wrong");
  pin_test_a: assert property (
    (up_q >= 13'h2 ##0 (!iface_sel_i && self_test_pin_i)[*6]) |->
    self_test_o)
    else $error("pin self-test ignored");
endmodule

bind ghs_top ghs_top_sva i_ghs_top_sva (.clock_i, .reset_n_i, .iface_sel_i,
  .self_test_pin_i, .checks_i, .sample_i, .ss_n_i, .miso_oe_o, .health_ok_o,
  .self_test_o, .adc_en_o, .rate_o);

`default_nettype wire

/* tb/ghs_top_test.sv */
// self-checking bench for the health monitor and spi message port
`timescale 1ns/1ps
`default_nettype none

module ghs_top_test;
  logic clock_i, reset_n_i, iface_sel_i, self_test_pin_i;
  ghs_pkg::ghs_checks_t checks_i;
  ghs_pkg::ghs_sample_t sample_i;
  logic sclk, ss_n, mosi, miso_o, miso_oe_o, health_ok_o, self_test_o;
  logic adc_en_o, range_spi_o;
  logic [15:0] rate_o;
  logic [1:0] range_sel_o;
  logic [47:0] rsp;
  logic [7:0] c;
  int errors, check_count, cyc, seed;

  ghs_top i_ghs_top (.clock_i, .reset_n_i, .iface_sel_i, .self_test_pin_i,
    .checks_i, .sample_i, .sclk_i(sclk), .ss_n_i(ss_n), .mosi_i(mosi),
    .miso_o, .miso_oe_o, .health_ok_o, .self_test_o, .adc_en_o, .rate_o,
    .range_sel_o, .range_spi_o);
  ghs_host i_ghs_host (.sclk_o(sclk), .ss_n_o(ss_n), .mosi_o(mosi),
    .miso_i(miso_o));

  // ============================================================
  // expectations
  function automatic logic [47:0] msg(input logic [39:0] b);
    logic [7:0] s;
    s = b[39:32] + b[31:24] + b[23:16] + b[15:8] + b[7:0];
    return {b, ~s};
  endfunction
  function automatic logic [15:0] rate_exp(input logic st);
    return st ? 16'(sample_i.rate + ghs_pkg::SELF_TEST_OFFSET) : sample_i.rate;
  endfunction
  function automatic logic [47:0] reply(input logic fail, bad, st);
    return msg({fail, 2'h0, bad, st, 3'h1, rate_exp(st), sample_i.temp});
  endfunction

  task automatic check(input logic [47:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // bad flips the checksum lsb so the frame must be refused
  task automatic send(input logic [7:0] cmd, input int nbits, input bit bad);
    i_ghs_host.xfer(msg({cmd, 32'($random(seed))}) ^ 48'(bad), nbits, rsp);
    cycles(10);
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // ceiling sits well above the roughly 60k cycles the run needs
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      conclude();
    end
  end

  initial begin
    seed = 98;
    reset_n_i = 1'b0;
    iface_sel_i = 1'b1;
    self_test_pin_i = 1'b0;
    checks_i = 6'h30;
    sample_i = {16'h0123, 16'h0258};
    cycles(20);
    reset_n_i = 1'b1;
    cycles(4000);
    check(health_ok_o, 0);
    cycles(1200);
    check({health_ok_o, adc_en_o}, 2'h3);
    send(8'h30, 48, 0);
    send(8'h30, 48, 0);
    check(rsp, reply(0, 0, 0));
    send(8'h70, 48, 0);
    check({self_test_o, health_ok_o}, 2'h2);
    send(8'h30, 20, 0);
    send(8'h30, 48, 1);
    check(self_test_o, 1);
    send(8'h70, 48, 0);
    check(rsp, reply(1, 1, 1));
    for (int i = 0; i < 8; i++) begin
      c = 8'($random(seed)) & 8'h78;
      sample_i = ghs_pkg::ghs_sample_t'($random(seed));
      send(c, 48, 0);
      check({range_spi_o, range_sel_o, self_test_o, rate_o},
        {c[5], c[4:3], c[6], rate_exp(c[6])});
      send(c, 48, 0);
      check(rsp, reply(c[6], 0, c[6]));
    end
    send(8'h30, 48, 0);
    iface_sel_i = 1'b0;
    self_test_pin_i = 1'b1;
    cycles(10);
    check({adc_en_o, self_test_o, health_ok_o}, 3'h2);
    iface_sel_i = 1'b1;
    self_test_pin_i = 1'b0;
    for (int k = 0; k < 4; k++) begin
      checks_i[k] = 1'b1;
      cycles(10);
      check(health_ok_o, 0);
      checks_i[k] = 1'b0;
      cycles(5100);
      check(health_ok_o, 1);
    end
    // power-up checks are only looked at after a reset
    for (int k = 4; k < 6; k++) begin
      checks_i[k] = 1'b0;
      reset_n_i = 1'b0;
      cycles(20);
      reset_n_i = 1'b1;
      cycles(5200);
      check(health_ok_o, 0);
      checks_i[k] = 1'b1;
    end
    conclude();
  end
endmodule

`default_nettype wire
